/* File: atb_pkg.sv */
// constants and types shared by the address translation buffer
package atb_pkg;

   localparam int ENTRY_COUNT = 28;
   localparam int PTR_W = 5;
   localparam int VPN_W = 23;
   localparam int VPN_LSB = 9;
   localparam int PFN_W = 21;
   localparam int PHYS_W = 30;
   localparam int PROTECTION_CODE_W = 4;
   localparam int PROTECTION_CODE_DEC_W = 8;
   localparam int IPR_NUM_W = 7;

   // internal processor register numbers
   localparam logic [IPR_NUM_W-1:0] IPR_TABLE_FIRST = 7'h08;
   localparam logic [IPR_NUM_W-1:0] IPR_TABLE_LAST = 7'h0D;
   localparam logic [IPR_NUM_W-1:0] IPR_MM_ENABLE = 7'h38;
   localparam logic [IPR_NUM_W-1:0] IPR_FLUSH_ALL = 7'h39;
   localparam logic [IPR_NUM_W-1:0] IPR_FLUSH_SINGLE = 7'h3A;
   localparam logic [IPR_NUM_W-1:0] IPR_PROBE = 7'h3F;

   localparam int MM_ENABLE_BIT = 0;
   localparam logic MM_ENABLE_RESET = 1'h0;
   localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
   localparam logic [PTR_W-1:0] PTR_LAST = 5'h1B;

   // protection predecode: [7:4] write allowed U,S,E,K; [3:0] read allowed
   localparam logic [15:0][PROTECTION_CODE_DEC_W-1:0] PROTECTION_CODE_DECODE = {
      8'h0F, 8'h1F, 8'h3F, 8'h7F, 8'h07, 8'h17, 8'h37, 8'h77,
      8'h03, 8'h13, 8'h33, 8'hFF, 8'h01, 8'h11, 8'h00, 8'h00};

   typedef struct packed {
      logic bufferEntryValid;
      logic [PFN_W-1:0] pageFrameNumber;
      logic tableEntryValid;
      logic tableEntryModified;
      logic [PROTECTION_CODE_DEC_W-1:0] protAccess;
   } atb_pte_t;

   typedef struct packed {
      logic [VPN_W-1:0] virtualPageNumber;
      atb_pte_t pte;
   } atb_entry_t;

   typedef struct packed {
      logic valid;
      logic [31:0] virtAddr;
   } atb_lookup_t;

   typedef struct packed {
      logic valid;
      logic [VPN_W-1:0] virtualPageNumber;
      logic [PFN_W-1:0] pageFrameNumber;
      logic tableEntryValid;
      logic tableEntryModified;
      logic [PROTECTION_CODE_W-1:0] protectionCode;
   } atb_refill_t;

   typedef struct packed {
      logic done;
      logic hit;
      logic miss;
      logic [PHYS_W-1:0] physAddr;
      logic tableEntryValid;
      logic tableEntryModified;
      logic [PROTECTION_CODE_DEC_W-1:0] protAccess;
   } atb_result_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [IPR_NUM_W-1:0] num;
      logic [31:0] data;
   } atb_reg_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } atb_reg_rsp_t;

   typedef struct packed {
      atb_entry_t [ENTRY_COUNT-1:0] entries;
      logic [PTR_W-1:0] replacePtr;
      logic mmEnable;
      atb_result_t result;
      atb_reg_rsp_t regRsp;
      logic overflowCcSet;
   } atb_state_t;

endpackage : atb_pkg

/* File: atb_translation_buffer.sv */
// fully associative address translation buffer with its control registers
//
// Operation
// [R01] holds 28 fully associative entries, each usable for process or system space
// [R02] any write to the memory management enable register flushes all entries
// [R03] writes to page table base or length registers 8..13 flush all entries
// [R04] flush-all write invalidates everything; flush-single write invalidates only matching entries
// [R05] each entry keeps a 23-bit tag holding the virtual page number
// [R06] entry data: frame number, table valid, modified, predecoded protection, valid
// [R07] lookup compares address bits 31..9 against all 28 tags at once
// [R08] exactly one matching tag gives a hit using that entry's data
// [R09] no matching tag reports a miss so the entry gets fetched
// [R10] refill writes new tag and entry into the slot the pointer selects
// [R11] accessing the pointed entry moves the pointer to the next entry
// [R12] memory management enable register is readable and writable
// [R13] flush-all register is write-only
// [R14] flush-single register is write-only and takes a virtual address
// [R15] probe register is write-only and takes an address inside the page
// [R16] writing 0 disables, 1 enables translation; read returns the state
// [R17] probe hit on a valid translation sets the overflow condition code
// [R18] flush-single invalidates entries mapping the written virtual address
// [R19] reset clears every entry valid flag and parks the pointer at zero
// [R20] an entry with its valid flag clear never hits
module atb_translation_buffer (
   input wire logic clk,
   input wire logic sys_rst,
   input wire atb_pkg::atb_lookup_t lookupReq,
   input wire atb_pkg::atb_refill_t refillReq,
   input wire atb_pkg::atb_reg_req_t regReq,
   output atb_pkg::atb_result_t lookupRsp,
   output atb_pkg::atb_reg_rsp_t regRsp,
   output logic mmEnable,
   output logic overflowCcSet
);
   import atb_pkg::*;

   localparam atb_state_t STATE_RESET = '{
      entries: '0,
      replacePtr: PTR_RESET,
      mmEnable: MM_ENABLE_RESET,
      result: '0,
      regRsp: '0,
      overflowCcSet: 1'h0};

   atb_state_t st;
   atb_state_t next_st;

   logic [ENTRY_COUNT-1:0] lookupMatch;
   logic [ENTRY_COUNT-1:0] regMatch;
   logic [VPN_W-1:0] lookupVpn;
   logic [VPN_W-1:0] regVpn;

   assign lookupVpn = lookupReq.virtAddr[31:VPN_LSB]; // [R07]
   assign regVpn = regReq.data[31:VPN_LSB];

   // one comparator pair per entry; a cleared valid flag masks the tag
   for (genvar i = 0; i < ENTRY_COUNT; i++) begin : g_cmp
      assign lookupMatch[i] = st.entries[i].pte.bufferEntryValid &&
         (st.entries[i].virtualPageNumber == lookupVpn); // [R07] [R20]
      assign regMatch[i] = st.entries[i].pte.bufferEntryValid &&
         (st.entries[i].virtualPageNumber == regVpn); // [R20]
   end

   function automatic logic [PTR_W-1:0] ptr_next(
      input logic [PTR_W-1:0] p
   );
      if (p == PTR_LAST) begin
         return PTR_RESET;
      end
      return p + 5'h01;
   endfunction : ptr_next

   always_comb begin
      logic singleHit;
      logic advance;
      logic tableWrite;
      logic [PTR_W-1:0] hitIdx;
      atb_entry_t hitEntry;
      singleHit = 1'h0;
      advance = 1'h0;
      tableWrite = 1'h0;
      hitIdx = PTR_RESET;
      hitEntry = '0;
      next_st = st;
      next_st.result = '0;
      next_st.regRsp = '0;
      next_st.overflowCcSet = 1'h0;

      // a double match should not happen; treated as a miss rather than
      // mixing two translations; the refill goes to the pointed slot
      singleHit = (lookupMatch != '0) &&
         ((lookupMatch & (lookupMatch - 1'b1)) == '0); // [R08]
      for (int i = 0; i < ENTRY_COUNT; i++) begin
         if (lookupMatch[i]) begin
            hitIdx = PTR_W'(i);
            hitEntry = st.entries[i];
         end
      end

      if (lookupReq.valid) begin
         next_st.result.done = 1'h1;
         if (!st.mmEnable) begin
            // translation off: the address passes through untranslated
            next_st.result.hit = 1'h1;
            next_st.result.physAddr = lookupReq.virtAddr[PHYS_W-1:0];
         end else if (singleHit) begin
            next_st.result.hit = 1'h1; // [R08]
            next_st.result.physAddr = {hitEntry.pte.pageFrameNumber,
               lookupReq.virtAddr[VPN_LSB-1:0]}; // [R08]
            next_st.result.tableEntryValid = hitEntry.pte.tableEntryValid;
            next_st.result.tableEntryModified =
               hitEntry.pte.tableEntryModified;
            next_st.result.protAccess = hitEntry.pte.protAccess;
            if (hitIdx == st.replacePtr) begin
               advance = 1'h1; // [R11]
            end
         end else begin
            next_st.result.miss = 1'h1; // [R09]
         end
      end

      if (refillReq.valid) begin
         next_st.entries[st.replacePtr].virtualPageNumber =
            refillReq.virtualPageNumber; // [R10] [R05]
         next_st.entries[st.replacePtr].pte = '{
            bufferEntryValid: 1'h1,
            pageFrameNumber: refillReq.pageFrameNumber,
            tableEntryValid: refillReq.tableEntryValid,
            tableEntryModified: refillReq.tableEntryModified,
            protAccess: PROTECTION_CODE_DECODE[refillReq.protectionCode]}; // [R06]
         // the slot just filled is the accessed one, so move past it
         advance = 1'h1; // [R11]
      end

      if (advance) begin
         next_st.replacePtr = ptr_next(st.replacePtr); // [R11]
      end

      // register moves come last so a full flush beats a same-cycle refill
      tableWrite = regReq.write && (regReq.num >= IPR_TABLE_FIRST) &&
         (regReq.num <= IPR_TABLE_LAST);
      if (regReq.write && (regReq.num == IPR_MM_ENABLE)) begin
         next_st.mmEnable = regReq.data[MM_ENABLE_BIT]; // [R16] [R12]
      end
      if ((regReq.write && ((regReq.num == IPR_MM_ENABLE) ||
            (regReq.num == IPR_FLUSH_ALL))) || tableWrite) begin
         for (int i = 0; i < ENTRY_COUNT; i++) begin
            next_st.entries[i].pte.bufferEntryValid = 1'h0; // [R02] [R03] [R04]
         end
      end
      if (regReq.write && (regReq.num == IPR_FLUSH_SINGLE)) begin
         for (int i = 0; i < ENTRY_COUNT; i++) begin
            if (regMatch[i]) begin
               next_st.entries[i].pte.bufferEntryValid = 1'h0; // [R18] [R14]
            end
         end
      end
      if (regReq.write && (regReq.num == IPR_PROBE)) begin
         next_st.overflowCcSet = (regMatch != '0); // [R17] [R15]
      end

      // write-only registers read back as zero
      if (regReq.read) begin
         next_st.regRsp.valid = 1'h1;
         if (regReq.num == IPR_MM_ENABLE) begin
            next_st.regRsp.data[MM_ENABLE_BIT] = st.mmEnable; // [R12] [R13]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= STATE_RESET; // [R19]
      end else begin
         st <= next_st;
      end
   end

   assign lookupRsp = st.result;
   assign regRsp = st.regRsp;
   assign mmEnable = st.mmEnable;
   assign overflowCcSet = st.overflowCcSet;

endmodule : atb_translation_buffer

/* File: atb_translation_buffer_asserts.sv */
// port checker for the address translation buffer
module atb_translation_buffer_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire atb_pkg::atb_lookup_t lookupReq,
   input wire atb_pkg::atb_reg_req_t regReq,
   input wire atb_pkg::atb_result_t lookupRsp,
   input wire atb_pkg::atb_reg_rsp_t regRsp,
   input wire logic mmEnable,
   input wire logic overflowCcSet
);
   import atb_pkg::*;
   logic [31:0] lastVa;
   logic lastBit;
   always_ff @(posedge clk) begin
      lastVa <= lookupReq.virtAddr;
      lastBit <= regReq.data[0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence flushAll_s;
      regReq.write && regReq.num == IPR_FLUSH_ALL;
   endsequence
   sequence mappedLook_s;
      lookupReq.valid && mmEnable;
   endsequence
   done_follows_a: assert property (lookupReq.valid |=> lookupRsp.done)
      else $error("lookup not answered");
   hit_xor_miss_a: assert property (lookupRsp.done |->
      lookupRsp.hit != lookupRsp.miss) else $error("hit and miss clash");
   identity_map_a: assert property (lookupReq.valid && !mmEnable |=>
      lookupRsp.hit && lookupRsp.physAddr == lastVa[29:0])
      else $error("unmapped address altered");
   enable_write_a: assert property (regReq.write &&
      regReq.num == IPR_MM_ENABLE |=> mmEnable == lastBit)
      else $error("enable not written");
   enable_read_a: assert property (regReq.read &&
      regReq.num == IPR_MM_ENABLE |=> regRsp.valid &&
      regRsp.data == {31'h0, $past(mmEnable)}) else $error("bad enable read");
   other_read_a: assert property (regReq.read &&
      regReq.num != IPR_MM_ENABLE |=> regRsp.valid && regRsp.data == '0)
      else $error("bad read answer");
   flush_kills_a: assert property (flushAll_s ##2 mappedLook_s
      |=> !lookupRsp.hit) else $error("hit after flush");
   probe_only_a: assert property (!(regReq.write &&
      regReq.num == IPR_PROBE) |=> !overflowCcSet) else $error("stray flag");
endmodule : atb_translation_buffer_asserts
bind atb_translation_buffer atb_translation_buffer_asserts
   atb_translation_buffer_asserts_i (.clk(clk), .sys_rst(sys_rst),
   .lookupReq(lookupReq), .regReq(regReq), .lookupRsp(lookupRsp),
   .regRsp(regRsp), .mmEnable(mmEnable), .overflowCcSet(overflowCcSet));

/* File: atb_core_model.sv */
// processor-side model: builds the entry from the address after a miss and refills
module atb_core_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire atb_pkg::atb_lookup_t lookupReq,
   input wire atb_pkg::atb_result_t lookupRsp,
   output atb_pkg::atb_refill_t refillReq
);
   timeunit 1ns;
   timeprecision 1ps;
   import atb_pkg::*;
   logic [31:0] va;
   atb_refill_t fetched;
   // entry is a pure function of the page so the bench can predict it
   assign fetched = '{1'b1, va[31:9], va[29:9] ^ 21'h0ABCD, 1'b1, va[9],
      va[12:9]};
   always @(posedge clk) begin
      if (sys_rst) begin
         refillReq <= '0;
      end else begin
         if (lookupReq.valid) begin
            va <= lookupReq.virtAddr;
         end
         // idle cycles show the inverted entry, never a stale copy
         refillReq <= lookupRsp.miss ? fetched : ~fetched;
      end
   end
endmodule : atb_core_model

/* File: atb_translation_buffer_tb.sv */
// self-checking bench for the address translation buffer
module atb_translation_buffer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import atb_pkg::*;
   logic clk;
   logic sys_rst;
   atb_lookup_t lookupReq;
   atb_refill_t refillReq;
   atb_reg_req_t regReq;
   atb_result_t lookupRsp;
   atb_reg_rsp_t regRsp;
   logic mmEnable;
   logic overflowCcSet;
   logic en;
   int miscompares;
   int n_tests;
   logic [6:0] flushNum [6] = '{7'h08, 7'h0A, 7'h0D, 7'h38, 7'h39, 7'h3A};
   localparam logic [31:0] A = 32'h0001_2345;
   atb_translation_buffer atb_translation_buffer_i (.clk(clk),
      .sys_rst(sys_rst), .lookupReq(lookupReq), .refillReq(refillReq),
      .regReq(regReq), .lookupRsp(lookupRsp), .regRsp(regRsp),
      .mmEnable(mmEnable), .overflowCcSet(overflowCcSet));
   atb_core_model atb_core_model_i (.clk(clk), .sys_rst(sys_rst),
      .lookupReq(lookupReq), .lookupRsp(lookupRsp), .refillReq(refillReq));
   always #25 clk = ~clk;
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask : chk
   task automatic wreg(input logic [6:0] num, input logic [31:0] d);
      @(posedge clk);
      regReq <= '{1'b1, 1'b0, num, d};
      @(posedge clk);
      regReq <= '0;
      #1;
   endtask : wreg
   task automatic rreg(input logic [6:0] num, input logic [31:0] exp);
      @(posedge clk);
      regReq <= '{1'b0, 1'b1, num, 32'h0};
      @(posedge clk);
      regReq <= '0;
      #1;
      chk({regRsp.valid, regRsp.data}, {1'b1, exp});
   endtask : rreg
   // one spare edge after the answer lets a refill land before the next use
   task automatic lk(input logic [31:0] va, input logic h);
      @(posedge clk);
      lookupReq <= '{1'b1, va};
      @(posedge clk);
      lookupReq <= '0;
      #1;
      chk({lookupRsp.done, lookupRsp.hit}, {1'b1, h});
      if (h) begin
         chk(lookupRsp.physAddr, en ? {va[29:9] ^ 21'h0ABCD, va[8:0]}
            : va[29:0]);
         if (en) chk(lookupRsp.protAccess, PROTECTION_CODE_DECODE[va[12:9]]);
         if (en) chk(lookupRsp.tableEntryModified, va[9]);
         if (en) chk(lookupRsp.tableEntryValid, 1'b1);
      end
      @(posedge clk);
   endtask : lk
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      lookupReq = '0;
      regReq = '0;
      en = 1'b0;
      miscompares = 0;
      n_tests = 0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rreg(7'h38, 32'h0);
      rreg(7'h10, 32'h0);
      lk(32'h8000_1234, 1'b1);
      wreg(7'h38, 32'h1);
      chk(mmEnable, 1'b1);
      en = 1'b1;
      rreg(7'h38, 32'h1);
      lk(A, 1'b0);
      lk(A, 1'b1);
      wreg(7'h3F, A);
      chk(overflowCcSet, 1'b1);
      wreg(7'h3F, A ^ 32'h200);
      chk(overflowCcSet, 1'b0);
      for (int i = 0; i < 6; i++) begin
         wreg(flushNum[i], A);
         lk(A, 1'b0);
         lk(A, 1'b1);
      end
      for (int i = 0; i < 28; i++) lk(32'h0040_0000 + (i << 9), 1'b0);
      for (int i = 0; i < 28; i++) lk(32'h0040_0000 + (i << 9), 1'b1);
      lk(32'h0040_0000 + (28 << 9), 1'b0);
      lk(32'h0040_0000, 1'b0);
      lk(32'h0040_0400, 1'b1);
      give_verdict();
   end
endmodule : atb_translation_buffer_tb
